// >>> bench/cansi_can_node.sv
// Behavioural model of the CAN bus side: frames, errors and line states
`timescale 1ns/10ps
module cansi_can_node (
    input wire ref_clk,
    input wire txStart,
    output wire busIdle,
    output wire rxStart,
    output wire rxDone,
    output wire [3:0] rxSlot,
    output wire storeDone,
    output wire txDone,
    output wire busErrorIn,
    output wire errPassiveIn,
    output wire busOffIn
);
    reg [6:0] lvl = 7'h00;
    reg idle = 1'b1;
    reg slow = 1'b0;
    reg [3:0] slotQ = 4'h0;
    assign {busOffIn, errPassiveIn, busErrorIn, txDone, storeDone, rxDone, rxStart} = lvl;
    assign busIdle = idle;
    assign rxSlot = slotQ;
    // Levels held 5 cycles, then 5 low, to clear the input synchronisers
    task automatic pulse(input integer k);
        @(posedge ref_clk);
        lvl[k] <= 1'b1;
        repeat (5) @(posedge ref_clk);
        lvl[k] <= 1'b0;
        repeat (5) @(posedge ref_clk);
    endtask
    task automatic startRx(input logic [3:0] s);
        slotQ <= s;
        pulse(0);
    endtask
    // answer only a started send; alternate prompt and slow frames
    initial forever begin
        @(posedge ref_clk);
        if (txStart === 1'b1) begin
            idle <= 1'b0;
            repeat (slow ? 40 : 6) @(posedge ref_clk);
            pulse(3);
            idle <= 1'b1;
            slow = ~slow;
        end
    end
endmodule

// >>> bench/cansi_slot_status_props.sv
// Port-level checker for the CAN slot status and interrupt block
`timescale 1ns/10ps
`include "cansi_map.vh"
module cansi_slot_status_props (
    input wire ref_clk,
    input wire rst,
    input wire [4:0] regAddr,
    input wire [15:0] regWrData,
    input wire regWrite,
    input wire regRead,
    input wire [15:0] regRdData,
    input wire busIdle,
    input wire busErrorIn,
    input wire txStart,
    input wire errorFrameStart,
    input wire moduleHalted,
    input wire combinedIrq,
    input wire [2:0] requestPending
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    wire ctrlWr = regWrite && (regAddr == `CANSI_A_CTRL);
    a_hold_halts: assert property (ctrlWr && regWrData[1:0] == 2'h3 |-> ##2 moduleHalted)
        else $error("halted flag not set after hold");
    a_release_runs: assert property (ctrlWr && regWrData[1:0] == 2'h0 |-> ##2 !moduleHalted)
        else $error("halted flag not cleared after release");
    a_halt_readback: assert property ($past(regRead) && $past(regAddr) == `CANSI_A_STAT
        |-> regRdData[0] == $past(moduleHalted))
        else $error("halted bit read back wrong");
    a_send_idle: assert property (txStart |-> busIdle && !moduleHalted)
        else $error("send began on busy bus or while halted");
    a_errfrm_cause: assert property ($rose(busErrorIn) && !moduleHalted |-> ##[2:8] errorFrameStart)
        else $error("no error frame after bus error");
    a_errfrm_pulse: assert property (errorFrameStart |=> !errorFrameStart)
        else $error("error frame start longer than one cycle");
    a_pend_on_edge: assert property ($rose(combinedIrq) |-> requestPending == 3'h7)
        else $error("pending bits not all set on request edge");
    a_pend_only_edge: assert property ((requestPending & ~$past(requestPending)) != 3'h0
        |-> $rose(combinedIrq))
        else $error("pending bit set without request edge");
    a_irq_holds: assert property (combinedIrq && !regWrite && !$past(regWrite) |=> combinedIrq)
        else $error("combined request dropped without software");
    a_pend_sticky: assert property (!regWrite |=> (requestPending & $past(requestPending))
        == $past(requestPending))
        else $error("pending bit cleared by hardware");
    cover property ($rose(combinedIrq));
    cover property (txStart);
    cover property (errorFrameStart);
endmodule
bind cansi_slot_status cansi_slot_status_props u_props (.ref_clk(ref_clk), .rst(rst),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .busIdle(busIdle), .busErrorIn(busErrorIn), .txStart(txStart),
    .errorFrameStart(errorFrameStart), .moduleHalted(moduleHalted),
    .combinedIrq(combinedIrq), .requestPending(requestPending));

// >>> bench/tb_cansi_slot_status.sv
// Self-checking testbench for the CAN slot status and interrupt block
`timescale 1ns/10ps
`include "cansi_map.vh"
module tb_cansi_slot_status;
    reg ref_clk = 1'b0;
    reg rst = 1'b1;
    reg [4:0] regAddr = 5'h00;
    reg [15:0] regWrData = 16'h0000;
    reg regWrite = 1'b0;
    reg regRead = 1'b0;
    wire [15:0] regRdData;
    wire busIdle, rxStart, rxDone, storeDone, txDone, busErrorIn, errPassiveIn, busOffIn;
    wire txStart, errorFrameStart, moduleHalted, combinedIrq;
    wire [3:0] rxSlot, txSlot;
    wire [2:0] requestPending;
    integer miscompares = 0;
    integer totalChecks = 0;
    integer i;
    integer n;
    logic [15:0] rdv;
    logic [15:0] sist = 16'h0000;
    logic [3:0] slot;
    logic sawErr = 1'b0;
    initial forever #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (errorFrameStart === 1'b1) sawErr <= 1'b1;
    cansi_slot_status dut (.ref_clk(ref_clk), .rst(rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .busIdle(busIdle), .rxStart(rxStart), .rxDone(rxDone), .rxSlot(rxSlot),
        .storeDone(storeDone), .busErrorIn(busErrorIn), .errPassiveIn(errPassiveIn),
        .busOffIn(busOffIn), .txStart(txStart), .txSlot(txSlot), .txDone(txDone),
        .errorFrameStart(errorFrameStart), .moduleHalted(moduleHalted),
        .combinedIrq(combinedIrq), .requestPending(requestPending));
    cansi_can_node node (.ref_clk(ref_clk), .txStart(txStart), .busIdle(busIdle),
        .rxStart(rxStart), .rxDone(rxDone), .rxSlot(rxSlot), .storeDone(storeDone),
        .txDone(txDone), .busErrorIn(busErrorIn), .errPassiveIn(errPassiveIn),
        .busOffIn(busOffIn));
    // ****************************************
    // Bus cycles, comparison and verdict
    // ****************************************
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        totalChecks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge ref_clk);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a);
        @(posedge ref_clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRead <= 1'b0;
        #1 rdv = regRdData;
    endtask
    function automatic logic [15:0] bitOf(input logic [3:0] s);
        bitOf = 16'h0001 << s;
    endfunction
    task stopTest;
        $display("checks %0d mismatches %0d", totalChecks, miscompares);
        if (miscompares == 0 && totalChecks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #100000;
        miscompares++;
        stopTest;
    end
    initial begin
        void'($urandom(32'hac23e866));
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        #1 chk(moduleHalted, 16'h1, "halted after reset");
        rd(`CANSI_A_CTRL); chk(rdv, 16'h0003, "hold bits after reset");
        wr(5'h0c, 16'hffff); rd(5'h0c); chk(rdv, 16'h0000, "unmapped read");
        wr(`CANSI_A_CTRL, 16'h0000); @(posedge ref_clk);
        #1 chk(moduleHalted, 16'h0, "halt released");
        wr(`CANSI_A_SIMK, 16'hffff); wr(`CANSI_A_EIMK, 16'h0007); wr(`CANSI_A_PENE, 16'h0007);
        $display("reset test done");
        for (i = 0; i < 2; i++) begin
            slot = (i == 0) ? 4'($urandom % 16) : 4'hf;
            sist = sist | bitOf(slot);
            wr(`CANSI_A_SLOT + 5'(slot), 16'h0001);
            n = 0;
            while (txStart !== 1'b1 && n < 100) begin @(posedge ref_clk); #1 n++; end
            chk(txSlot, slot, "send slot");
            rd(`CANSI_A_SLOT + 5'(slot)); chk(rdv[2], 16'h1, "slot sending");
            rd(`CANSI_A_STAT); chk(rdv[1], 16'h1, "global sending");
            n = 0;
            while (busIdle !== 1'b1 && n < 200) begin @(posedge ref_clk); n++; end
            repeat (6) @(posedge ref_clk);
            rd(`CANSI_A_STAT); chk(rdv, {4'h0, slot, 8'h08}, "status after send");
            rd(`CANSI_A_SLOT + 5'(slot)); chk(rdv[5:0], 16'h08, "slot after send");
            rd(`CANSI_A_SIST); chk(rdv, sist, "slot irq status");
            chk(combinedIrq, 16'h1, "combined request");
            chk(requestPending, 16'h7, "pending bits");
            rd(`CANSI_A_ICR); chk(rdv, (i == 0) ? 16'h7 : 16'h0, "control request");
            wr(`CANSI_A_ICR, 16'h0000);
        end
        wr(`CANSI_A_SIST, 16'h0000); wr(`CANSI_A_PEND, 16'h0000); repeat (3) @(posedge ref_clk);
        #1 chk({combinedIrq, requestPending}, 16'h0, "cleared by software");
        $display("send test done");
        slot = 4'($urandom % 16);
        wr(`CANSI_A_SLOT + 5'(slot), 16'h0002);
        repeat ($urandom % 50) @(posedge ref_clk);
        node.startRx(slot);
        rd(`CANSI_A_STAT); chk(rdv[2], 16'h1, "global receiving");
        node.pulse(1);
        rd(`CANSI_A_SLOT + 5'(slot)); chk(rdv[5:4], 16'h3, "storing and fresh");
        // Send success from the send test is still set: only software clears it
        rd(`CANSI_A_STAT); chk(rdv[4:2], 16'h6, "receive ok, not receiving");
        node.pulse(2);
        rd(`CANSI_A_SLOT + 5'(slot)); chk(rdv[5:4], 16'h2, "store finished");
        rd(`CANSI_A_STAT); chk(rdv[11:8], slot, "last slot");
        rd(`CANSI_A_SIST); chk(rdv, bitOf(slot), "receive irq status");
        chk(combinedIrq, 16'h1, "receive request");
        wr(`CANSI_A_SIST, 16'h0000); wr(`CANSI_A_PEND, 16'h0000);
        $display("receive test done");
        for (i = 0; i < 3; i++) begin
            node.pulse(4 + i);
            rd(`CANSI_A_EIST); chk(rdv, 16'h1 << i, "error irq status");
            chk(requestPending, 16'h7, "error request edge");
            wr(`CANSI_A_EIST, 16'h0000); wr(`CANSI_A_PEND, 16'h0000);
        end
        chk(sawErr, 16'h1, "error frame started");
        rd(`CANSI_A_STAT); chk(rdv[5], 16'h1, "bus fault flag");
        wr(`CANSI_A_EIMK, 16'h0000); node.pulse(4); repeat (3) @(posedge ref_clk);
        #1 chk(combinedIrq, 16'h0, "masked error");
        wr(`CANSI_A_EIST, 16'h0000); wr(`CANSI_A_CTRL, 16'h0003); @(posedge ref_clk);
        #1 chk(moduleHalted, 16'h1, "halted again");
        node.pulse(4); rd(`CANSI_A_EIST); chk(rdv, 16'h0, "event ignored while halted");
        $display("error test done");
        stopTest;
    end
endmodule

// >>> design/cansi_map.vh
// Register offsets, field positions and reset values for the CAN slot status block
`ifndef CANSI_MAP_VH
`define CANSI_MAP_VH
`define CANSI_AW 5
`define CANSI_A_CTRL 5'h00
`define CANSI_A_STAT 5'h01
`define CANSI_A_SIST 5'h02
`define CANSI_A_SIMK 5'h03
`define CANSI_A_EIST 5'h04
`define CANSI_A_EIMK 5'h05
`define CANSI_A_PEND 5'h06
`define CANSI_A_PENE 5'h07
`define CANSI_A_ICR 5'h08
`define CANSI_A_SLOT 5'h10
`define CANSI_CTRL_HOLDA 0
`define CANSI_CTRL_HOLDB 1
`define CANSI_ST_HALTED 0
`define CANSI_ST_SENDING 1
`define CANSI_ST_RECEIVING 2
`define CANSI_ST_SENDOK 3
`define CANSI_ST_RECVOK 4
`define CANSI_ST_BUSFLT 5
`define CANSI_ST_LAST_LO 8
`define CANSI_ST_LAST_HI 11
`define CANSI_EI_BUSFLT 0
`define CANSI_EI_PASSIVE 1
`define CANSI_EI_BUSOFF 2
`define CANSI_SC_SENDREQ 0
`define CANSI_SC_RECVREQ 1
`define CANSI_SC_SENDING 2
`define CANSI_SC_SENT 3
`define CANSI_SC_STORING 4
`define CANSI_SC_FRESH 5
`define CANSI_CTRL_RST 2'h3
`endif

// >>> design/cansi_slot_status.v
// CAN slot status sequencing and interrupt request combining
//
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/10ps
`include "cansi_map.vh"

// Function
// RL1: Both hold bits set: enter module reset, then set halted flag.
// RL2: Both hold bits cleared: clear halted flag; bus activity then allowed.
// RL3: Send request with idle bus sets slot sending flag and global sending flag.
// RL4: Send done sets sent flag, send success, slot irq status, last slot.
// RL5: Slot with receive request armed; accepts matching frame anytime after.
// RL6: Reception start sets global receiving flag.
// RL7: Reception done sets storing flag, fresh frame flag, receive success.
// RL8: After store, clear storing flag, set slot irq status, record last slot.
// RL9: Bus error sets bus fault flag and its irq status; error frame starts.
// RL10: Interrupt sources: slot send, slot receive, bus fault, passive, bus-off.
// RL11: Error irq status has one bit each for fault, passive, bus-off.
// RL12: Combined request is OR of status bits ANDed with masks.
// RL13: Rising edge of combined request sets all three shared pending bits.
// RL14: Enabled pending bit sets matching interrupt control request bit.
// RL15: Further sources while request high cause no new edge or changes.
// RL16: Status and pending bits cleared only by software writing zero.
// RL17: Software must clear pending and enabled status before new interrupts.
// RL18: End of send clears sending flags; end of reception clears receiving flag.
module cansi_slot_status (
    input wire ref_clk,
    input wire rst,
    input wire [4:0] regAddr,
    input wire [15:0] regWrData,
    input wire regWrite,
    input wire regRead,
    output reg [15:0] regRdData,
    input wire busIdle,
    input wire rxStart,
    input wire rxDone,
    input wire [3:0] rxSlot,
    input wire storeDone,
    input wire busErrorIn,
    input wire errPassiveIn,
    input wire busOffIn,
    output reg txStart,
    output reg [3:0] txSlot,
    input wire txDone,
    output reg errorFrameStart,
    output reg moduleHalted,
    output reg combinedIrq,
    output reg [2:0] requestPending
);
    // ****************************************
    // Input synchronisers (three stages, last two must agree)
    // ****************************************
    reg [6:0] s1;
    reg [6:0] s2;
    reg [6:0] s3;
    reg [6:0] inLvl;
    reg [6:0] inPrev;
    wire [6:0] rawIn = {busOffIn, errPassiveIn, busErrorIn, storeDone, rxDone, rxStart, txDone};
    wire [6:0] rise = inLvl & ~inPrev;
    wire evTxDone = rise[0];
    wire evRxStart = rise[1];
    wire evRxDone = rise[2];
    wire evStore = rise[3];
    wire evBusErr = rise[4];
    wire evPassive = rise[5];
    wire evBusOff = rise[6];
    reg idl1;
    reg idl2;
    reg idl3;
    reg idleLvl;
    reg [3:0] rs1;
    reg [3:0] rs2;
    reg [3:0] rs3;
    reg [3:0] rxSlotLvl;
    integer k;

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s1 <= 7'h00;
            s2 <= 7'h00;
            s3 <= 7'h00;
            inLvl <= 7'h00;
            inPrev <= 7'h00;
            idl1 <= 1'b0;
            idl2 <= 1'b0;
            idl3 <= 1'b0;
            idleLvl <= 1'b0;
            rs1 <= 4'h0;
            rs2 <= 4'h0;
            rs3 <= 4'h0;
            rxSlotLvl <= 4'h0;
        end else begin
            s1 <= rawIn;
            s2 <= s1;
            s3 <= s2;
            for (k = 0; k < 7; k = k + 1) begin
                if (s2[k] == s3[k]) begin
                    inLvl[k] <= s3[k];
                end
            end
            inPrev <= inLvl;
            idl1 <= busIdle;
            idl2 <= idl1;
            idl3 <= idl2;
            if (idl2 == idl3) begin
                idleLvl <= idl3;
            end
            rs1 <= rxSlot;
            rs2 <= rs1;
            rs3 <= rs2;
            if (rs2 == rs3) begin
                rxSlotLvl <= rs3;
            end
        end
    end

    // ****************************************
    // Status state
    // ****************************************
    reg [1:0] hold;
    reg sending;
    reg receiving;
    reg sendOk;
    reg recvOk;
    reg busFault;
    reg [3:0] lastSlot;
    reg [15:0] sendReq;
    reg [15:0] recvReq;
    reg [15:0] slotSending;
    reg [15:0] slotSent;
    reg [15:0] slotStoring;
    reg [15:0] slotFresh;
    reg [15:0] slotIrq;
    reg [15:0] slotMask;
    reg [2:0] errIrq;
    reg [2:0] errMask;
    reg [2:0] pendEn;
    reg [3:0] storeSlot;
    reg [3:0] pick;
    reg found;
    integer j;

    wire [3:0] regSlot = regAddr[3:0];
    wire slotAcc = (regAddr[4] == 1'b1);
    wire wrCtrl = regWrite && regAddr == `CANSI_A_CTRL;
    wire wrSlot = regWrite && slotAcc;
    wire running = ~moduleHalted && ~hold[`CANSI_CTRL_HOLDA] && ~hold[`CANSI_CTRL_HOLDB];
    wire next_combined = |(slotIrq & slotMask) | |(errIrq & errMask);

    // Lowest numbered requesting slot wins arbitration
    always @* begin
        pick = 4'h0;
        found = 1'b0;
        for (j = 15; j >= 0; j = j - 1) begin
            if (sendReq[j]) begin
                pick = j[3:0];
                found = 1'b1;
            end
        end
    end

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            hold <= `CANSI_CTRL_RST;
            moduleHalted <= 1'b1;
            sending <= 1'b0;
            receiving <= 1'b0;
            sendOk <= 1'b0;
            recvOk <= 1'b0;
            busFault <= 1'b0;
            lastSlot <= 4'h0;
            sendReq <= 16'h0000;
            recvReq <= 16'h0000;
            slotSending <= 16'h0000;
            slotSent <= 16'h0000;
            slotStoring <= 16'h0000;
            slotFresh <= 16'h0000;
            slotIrq <= 16'h0000;
            slotMask <= 16'h0000;
            errIrq <= 3'h0;
            errMask <= 3'h0;
            pendEn <= 3'h0;
            storeSlot <= 4'h0;
            txStart <= 1'b0;
            txSlot <= 4'h0;
            errorFrameStart <= 1'b0;
            combinedIrq <= 1'b0;
            requestPending <= 3'h0;
        end else begin
            txStart <= 1'b0;
            errorFrameStart <= 1'b0;
            if (wrCtrl) begin
                hold <= regWrData[1:0];
            end
            // RL1 RL2 halted flag follows hold bits
            if (hold == 2'h3) begin
                moduleHalted <= 1'b1;
            end else if (hold == 2'h0) begin
                moduleHalted <= 1'b0;
            end
            // Software writes to slot control; sent and fresh flags clear on written zero
            if (wrSlot) begin
                sendReq[regSlot] <= regWrData[`CANSI_SC_SENDREQ];
                recvReq[regSlot] <= regWrData[`CANSI_SC_RECVREQ];
                slotSent[regSlot] <= slotSent[regSlot] & regWrData[`CANSI_SC_SENT];
                slotFresh[regSlot] <= slotFresh[regSlot] & regWrData[`CANSI_SC_FRESH];
            end
            if (regWrite && regAddr == `CANSI_A_STAT) begin
                sendOk <= sendOk & regWrData[`CANSI_ST_SENDOK];
                recvOk <= recvOk & regWrData[`CANSI_ST_RECVOK];
                busFault <= busFault & regWrData[`CANSI_ST_BUSFLT];
            end
            if (regWrite && regAddr == `CANSI_A_SIMK) begin
                slotMask <= regWrData;
            end
            if (regWrite && regAddr == `CANSI_A_EIMK) begin
                errMask <= regWrData[2:0];
            end
            if (regWrite && regAddr == `CANSI_A_PENE) begin
                pendEn <= regWrData[2:0];
            end
            // RL16 software-only clears; hardware sets below win
            if (regWrite && regAddr == `CANSI_A_SIST) begin
                slotIrq <= slotIrq & regWrData;
            end
            if (regWrite && regAddr == `CANSI_A_EIST) begin
                errIrq <= errIrq & regWrData[2:0];
            end
            if (regWrite && regAddr == `CANSI_A_PEND) begin
                requestPending <= requestPending & regWrData[2:0];
            end
            if (running) begin
                // RL3 start sending from idle bus
                if (!sending && !receiving && idleLvl && found) begin
                    sending <= 1'b1;
                    slotSending[pick] <= 1'b1;
                    sendReq[pick] <= 1'b0;
                    txSlot <= pick;
                    txStart <= 1'b1;
                end
                // RL4 RL18 send completion
                if (sending && evTxDone) begin
                    sending <= 1'b0;
                    slotSending[txSlot] <= 1'b0;
                    slotSent[txSlot] <= 1'b1;
                    sendOk <= 1'b1;
                    slotIrq[txSlot] <= 1'b1;
                    lastSlot <= txSlot;
                end
                // RL6 reception start
                if (evRxStart) begin
                    receiving <= 1'b1;
                end
                // RL5 RL7 RL18 accept into the received slot only when armed
                if (receiving && evRxDone) begin
                    receiving <= 1'b0;
                    if (recvReq[rxSlotLvl]) begin
                        slotStoring[rxSlotLvl] <= 1'b1;
                        slotFresh[rxSlotLvl] <= 1'b1;
                        recvOk <= 1'b1;
                        storeSlot <= rxSlotLvl;
                    end
                end
                // RL8 store finished
                if (evStore && slotStoring[storeSlot]) begin
                    slotStoring[storeSlot] <= 1'b0;
                    slotIrq[storeSlot] <= 1'b1;
                    lastSlot <= storeSlot;
                end
                // RL9 RL10 RL11 error events
                if (evBusErr) begin
                    busFault <= 1'b1;
                    errIrq[`CANSI_EI_BUSFLT] <= 1'b1;
                    errorFrameStart <= 1'b1;
                end
                if (evPassive) begin
                    errIrq[`CANSI_EI_PASSIVE] <= 1'b1;
                end
                if (evBusOff) begin
                    errIrq[`CANSI_EI_BUSOFF] <= 1'b1;
                end
            end
            // RL12 combined request
            combinedIrq <= next_combined;
            // RL13 RL15 RL17 only a rising edge sets pending bits
            if (next_combined && !combinedIrq) begin
                requestPending <= 3'h7;
            end
        end
    end

    // ****************************************
    // Interrupt control request bits
    // ****************************************
    reg [2:0] icReq;
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            icReq <= 3'h0;
        end else begin
            if (regWrite && regAddr == `CANSI_A_ICR) begin
                icReq <= icReq & regWrData[2:0];
            end
            // RL14 enabled pending bits raise control request
            if (next_combined && !combinedIrq) begin
                icReq <= icReq | pendEn;
            end
        end
    end

    // ****************************************
    // Register read port
    // ****************************************
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            regRdData <= 16'h0000;
        end else begin
            regRdData <= 16'h0000;
            if (regRead && slotAcc) begin
                regRdData[`CANSI_SC_SENDREQ] <= sendReq[regSlot];
                regRdData[`CANSI_SC_RECVREQ] <= recvReq[regSlot];
                regRdData[`CANSI_SC_SENDING] <= slotSending[regSlot];
                regRdData[`CANSI_SC_SENT] <= slotSent[regSlot];
                regRdData[`CANSI_SC_STORING] <= slotStoring[regSlot];
                regRdData[`CANSI_SC_FRESH] <= slotFresh[regSlot];
            end else if (regRead) begin
                case (regAddr)
                    `CANSI_A_CTRL: regRdData[1:0] <= hold;
                    `CANSI_A_STAT: regRdData <= {4'h0, lastSlot, 2'h0, busFault, recvOk,
                        sendOk, receiving, sending, moduleHalted};
                    `CANSI_A_SIST: regRdData <= slotIrq;
                    `CANSI_A_SIMK: regRdData <= slotMask;
                    `CANSI_A_EIST: regRdData[2:0] <= errIrq;
                    `CANSI_A_EIMK: regRdData[2:0] <= errMask;
                    `CANSI_A_PEND: regRdData[2:0] <= requestPending;
                    `CANSI_A_PENE: regRdData[2:0] <= pendEn;
                    `CANSI_A_ICR: regRdData[2:0] <= icReq;
                    default: regRdData <= 16'h0000;
                endcase
            end
        end
    end
endmodule
